// ---- shared/etx_pkg.sv ----
/*
  Shared constants and types of the Ethernet transmit buffer command path:
  register byte addresses, command and status word field positions, and the
  result bundle reported by the MAC after each packet.
  Assumes a 32-bit APB register bus and a MAC that reports one result per packet.
*/
package etx_pkg;

  // Register byte addresses
  localparam logic [11:0] ADDR_DATA   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_CFG    = 12'h008;
  localparam logic [11:0] ADDR_INFO   = 12'h00c;

  // First command word fields
  localparam int CA_SIZE_LSB  = 0;
  localparam int CA_SIZE_W    = 11;
  localparam int CA_LS_BIT    = 12;
  localparam int CA_FS_BIT    = 13;
  localparam int CA_OFF_LSB   = 16;
  localparam int CA_OFF_W     = 5;
  localparam int CA_ALIGN_LSB = 24;

  // End alignment codes and their byte masks
  localparam logic [1:0]  ALIGN_4     = 2'h0;
  localparam logic [1:0]  ALIGN_16    = 2'h1;
  localparam logic [11:0] MASK_4      = 12'h003;
  localparam logic [11:0] MASK_16     = 12'h00f;
  localparam logic [11:0] MASK_32     = 12'h01f;

  // Second command word fields
  localparam int CB_LEN_LSB   = 0;
  localparam int CB_LEN_W     = 11;
  localparam int CB_NOPAD_BIT = 12;
  localparam int CB_NOCRC_BIT = 13;
  localparam int TAG_LSB      = 16;
  localparam int TAG_W        = 16;

  // Status word fields
  localparam int ST_DEFERRED  = 0;
  localparam int ST_RSVD1     = 1;
  localparam int ST_EXDEFER   = 2;
  localparam int ST_CCOUNT    = 3;
  localparam int ST_EXCOL     = 8;
  localparam int ST_LATECOL   = 9;
  localparam int ST_NOCARR    = 10;
  localparam int ST_LOSSCARR  = 11;
  localparam int ST_ERRSUM    = 15;

  // Configuration and information register fields
  localparam int CFG_SAO_BIT   = 0;
  localparam int CFG_DEFER_BIT = 1;
  localparam int INFO_ERR_BIT  = 16;

  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  typedef struct packed {
    logic       loss_carrier;
    logic       no_carrier;
    logic       late_collision;
    logic       excess_collisions;
    logic [3:0] collision_count;
    logic       excess_deferral;
    logic       deferred;
  } etx_mac_result_s;

  typedef enum {W_CMDA, W_CMDB, W_DATA} etx_wstate_e;
  typedef enum {R_IDLE, R_CMDA, R_CMDB, R_DATA, R_EOP, R_WAIT} etx_rstate_e;

endpackage

// ---- rtl/etx_tx_path.sv ----
/*
  Transmit buffer command path: takes host-written transmit buffers over APB,
  strips offsets, alignment and command words, stores packets whole and
  hands them byte by byte to the MAC, then queues one status word per packet unless a status FIFO overrun drops it.
  Assumes a MAC that accepts bytes on valid/ready and pulses mac_done with
  its result after each packet end marker; one clock, pclk.
*/
`timescale 1ns/1ns
module etx_tx_path #(
  parameter int DDEPTH = 512,
  parameter int SDEPTH = 16
) (
  // APB slave
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // MAC byte stream
  output logic                        mac_valid,
  output logic [7:0]                  mac_data,
  input  wire logic                   mac_ready,
  output logic                        mac_eop,
  output logic                        mac_no_crc,
  output logic                        mac_no_pad,
  output logic                        mac_defer_check_en,
  // MAC result
  input  wire logic                   mac_done,
  input  wire etx_pkg::etx_mac_result_s mac_result,
  // Status
  output logic                        transmit_error_flag
);

  localparam int DAW = $clog2(DDEPTH);
  localparam int SAW = $clog2(SDEPTH);

  if (DDEPTH < 8 || (1 << DAW) != DDEPTH || SDEPTH < 2 || (1 << SAW) != SDEPTH)
  begin : g_bad_depth
    $error("etx_tx_path: depths must be powers of two, data at least 8");
  end

  // APB access phase bookkeeping
  logic        pready_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        acc;
  logic        wr_data_evt;
  logic        rd_status_evt;
  logic        wr_cfg_evt;
  logic        wr_info_evt;

  assign acc           = psel & penable & pready_q;
  assign wr_data_evt   = acc & pwrite & (paddr == etx_pkg::ADDR_DATA);
  assign rd_status_evt = acc & ~pwrite & (paddr == etx_pkg::ADDR_STATUS);
  assign wr_cfg_evt    = acc & pwrite & (paddr == etx_pkg::ADDR_CFG);
  assign wr_info_evt   = acc & pwrite & (paddr == etx_pkg::ADDR_INFO);

  // Configuration
  logic sao_q;
  logic defer_en_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sao_q      <= 1'b0;
      defer_en_q <= 1'b0;
    end
    else if (wr_cfg_evt)
    begin
      sao_q      <= pwdata[etx_pkg::CFG_SAO_BIT];
      defer_en_q <= pwdata[etx_pkg::CFG_DEFER_BIT];
    end
  end

  // Transmit data FIFO (commands and stripped payload words)
  logic [31:0]  dmem [DDEPTH];
  logic [DAW:0] dwp_q;
  logic [DAW:0] drp_q;
  logic         dfull;
  logic         dpush;
  logic [31:0]  dpush_data;
  logic         dpop;
  logic [31:0]  dhead;

  assign dfull = (dwp_q[DAW] != drp_q[DAW]) && (dwp_q[DAW-1:0] == drp_q[DAW-1:0]);
  assign dhead = dmem[drp_q[DAW-1:0]];

  always_ff @(posedge pclk)
  begin
    if (dpush && !dfull)
      dmem[dwp_q[DAW-1:0]] <= dpush_data;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dwp_q <= '0;
      drp_q <= '0;
    end
    else
    begin
      if (dpush && !dfull)
        dwp_q <= dwp_q + 1'b1;
      if (dpop)
        drp_q <= drp_q + 1'b1;
    end
  end

  // Host write side
  etx_pkg::etx_wstate_e wst_q;
  logic [31:0] cmda_q;
  logic [9:0]  widx_q;
  logic [9:0]  wtotal_q;
  logic [9:0]  wfirst_q;
  logic [9:0]  wlast_q;
  logic        whas_q;
  logic [31:0] pkt_cmdb_q;
  logic [11:0] sum_q;
  logic        buf_done;
  logic        pkt_done;
  logic        len_err;
  logic        cmdb_err;

  logic [4:0]  a_off;
  logic [10:0] a_size;
  logic [11:0] a_end;
  logic [11:0] a_mask;
  logic [11:0] a_total;
  logic [11:0] a_last;

  assign a_off  = pwdata[etx_pkg::CA_OFF_LSB +: etx_pkg::CA_OFF_W];
  assign a_size = pwdata[etx_pkg::CA_SIZE_LSB +: etx_pkg::CA_SIZE_W];
  assign a_end  = {7'h00, a_off} + {1'b0, a_size};
  assign a_last = a_end - 12'h001;

  always_comb
  begin
    if (pwdata[etx_pkg::CA_ALIGN_LSB +: 2] == etx_pkg::ALIGN_4)
      a_mask = etx_pkg::MASK_4;
    else if (pwdata[etx_pkg::CA_ALIGN_LSB +: 2] == etx_pkg::ALIGN_16)
      a_mask = etx_pkg::MASK_16;
    else
      a_mask = etx_pkg::MASK_32;
  end

  assign a_total = (a_end + a_mask) & ~a_mask;

  always_comb
  begin
    dpush      = 1'b0;
    dpush_data = pwdata;
    buf_done   = 1'b0;
    if (wr_data_evt)
    begin
      case (wst_q)
        etx_pkg::W_CMDA:
          dpush = 1'b1;
        // command B only on first segment
        etx_pkg::W_CMDB:
        begin
          dpush    = cmda_q[etx_pkg::CA_FS_BIT];
          buf_done = (wtotal_q == 10'h000);
        end
        default:
        begin
          // whole leading and trailing words dropped
          dpush    = whas_q && (widx_q >= wfirst_q) && (widx_q <= wlast_q);
          buf_done = (widx_q == wtotal_q - 10'h001);
        end
      endcase
    end
  end

  logic [11:0] sum_d;
  logic [11:0] sum_cur;
  logic [31:0] cmdb_cur;

  // A packet can end at command B (no data words), before sum and command B are stored
  assign sum_d    = (cmda_q[etx_pkg::CA_FS_BIT] ? 12'h000 : sum_q) +
                    {1'b0, cmda_q[etx_pkg::CA_SIZE_LSB +: etx_pkg::CA_SIZE_W]};
  assign sum_cur  = (wst_q == etx_pkg::W_CMDB) ? sum_d : sum_q;
  assign cmdb_cur = ((wst_q == etx_pkg::W_CMDB) && cmda_q[etx_pkg::CA_FS_BIT]) ?
                    pwdata : pkt_cmdb_q;

  assign pkt_done = buf_done & cmda_q[etx_pkg::CA_LS_BIT];
  // packet length check at last segment
  assign len_err  = pkt_done &&
                    (sum_cur != {1'b0, cmdb_cur[etx_pkg::CB_LEN_LSB +: etx_pkg::CB_LEN_W]});
  assign cmdb_err = wr_data_evt && (wst_q == etx_pkg::W_CMDB) &&
                    !cmda_q[etx_pkg::CA_FS_BIT] && (pwdata != pkt_cmdb_q);

  // command A, command B, then data words
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wst_q      <= etx_pkg::W_CMDA;
      cmda_q     <= '0;
      widx_q     <= '0;
      wtotal_q   <= '0;
      wfirst_q   <= '0;
      wlast_q    <= '0;
      whas_q     <= 1'b0;
      pkt_cmdb_q <= '0;
      sum_q      <= '0;
    end
    else if (wr_data_evt)
    begin
      case (wst_q)
        etx_pkg::W_CMDA:
        begin
          cmda_q   <= pwdata;
          wfirst_q <= {7'h00, a_off[4:2]};
          wlast_q  <= a_last[11:2];
          whas_q   <= (a_size != 11'h000);
          wtotal_q <= a_total[11:2];
          wst_q    <= etx_pkg::W_CMDB;
        end
        etx_pkg::W_CMDB:
        begin
          if (cmda_q[etx_pkg::CA_FS_BIT])
            pkt_cmdb_q <= pwdata;
          sum_q  <= sum_d;
          widx_q <= '0;
          wst_q  <= buf_done ? etx_pkg::W_CMDA : etx_pkg::W_DATA;
        end
        default:
        begin
          widx_q <= widx_q + 10'h001;
          if (buf_done)
            wst_q <= etx_pkg::W_CMDA;
        end
      endcase
    end
  end

  // Complete packets waiting in the data FIFO (store and forward)
  logic [DAW:0] pkt_cnt_q;
  logic         pkt_take;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pkt_cnt_q <= '0;
    else if (pkt_done && !pkt_take)
      pkt_cnt_q <= pkt_cnt_q + 1'b1;
    else if (pkt_take && !pkt_done)
      pkt_cnt_q <= pkt_cnt_q - 1'b1;
  end

  // Status FIFO
  logic [31:0]  smem [SDEPTH];
  logic [SAW:0] swp_q;
  logic [SAW:0] srp_q;
  logic [SAW:0] scount;
  logic         sfull;
  logic         sempty;
  logic         spush_req;
  logic         spush;
  logic [31:0]  sword;
  logic         spop;
  logic         ovr_q;

  assign scount = swp_q - srp_q;
  assign sfull  = (scount == SDEPTH[SAW:0]);
  assign sempty = (scount == '0);
  assign spop   = rd_status_evt & ~sempty;
  // no status written after an overrun until space freed
  assign spush  = spush_req & ~sfull & ~ovr_q;

  always_ff @(posedge pclk)
  begin
    if (spush)
      smem[swp_q[SAW-1:0]] <= sword;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      swp_q <= '0;
      srp_q <= '0;
      ovr_q <= 1'b0;
    end
    else
    begin
      if (spush)
        swp_q <= swp_q + 1'b1;
      if (spop)
        srp_q <= srp_q + 1'b1;
      if (spush_req && sfull && sao_q)
        ovr_q <= 1'b1;
      else if (spop)
        ovr_q <= 1'b0;
    end
  end

  always_comb
  begin
    sword = etx_pkg::STATUS_RESET;
    sword[etx_pkg::TAG_LSB +: etx_pkg::TAG_W] = pkt_cmdb_q[etx_pkg::TAG_LSB +: etx_pkg::TAG_W];
    sword[etx_pkg::ST_LOSSCARR] = mac_result.loss_carrier;
    sword[etx_pkg::ST_NOCARR]   = mac_result.no_carrier;
    sword[etx_pkg::ST_LATECOL]  = mac_result.late_collision;
    sword[etx_pkg::ST_EXCOL]    = mac_result.excess_collisions;
    sword[etx_pkg::ST_CCOUNT +: 4] = mac_result.collision_count;
    sword[etx_pkg::ST_EXDEFER]  = mac_result.excess_deferral & defer_en_q;
    sword[etx_pkg::ST_DEFERRED] = mac_result.deferred;
    sword[etx_pkg::ST_ERRSUM]   = sword[etx_pkg::ST_LOSSCARR] | sword[etx_pkg::ST_NOCARR] |
                                  sword[etx_pkg::ST_LATECOL] | sword[etx_pkg::ST_EXCOL] |
                                  sword[etx_pkg::ST_EXDEFER] | sword[etx_pkg::ST_RSVD1];
  end

  // MAC drain side
  etx_pkg::etx_rstate_e rst_q;
  logic [10:0] rrem_q;
  logic [1:0]  lane_q;
  logic        rls_q;
  logic        slot_free;
  logic        can_start;

  assign slot_free = ~mac_valid | mac_ready;
  // suspend while status FIFO full unless overrun allowed
  assign can_start = (pkt_cnt_q != '0) && (!sfull || sao_q);
  assign pkt_take  = (rst_q == etx_pkg::R_IDLE) && can_start;
  assign spush_req = (rst_q == etx_pkg::R_WAIT) && mac_done;

  always_comb
  begin
    dpop = 1'b0;
    case (rst_q)
      etx_pkg::R_CMDA:
        dpop = 1'b1;
      etx_pkg::R_CMDB:
        dpop = 1'b1;
      etx_pkg::R_DATA:
        // last partial word popped without its spare bytes
        dpop = slot_free && ((lane_q == 2'h3) || (rrem_q == 11'h001));
      default:
        dpop = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rst_q      <= etx_pkg::R_IDLE;
      rrem_q     <= '0;
      lane_q     <= '0;
      rls_q      <= 1'b0;
      mac_valid  <= 1'b0;
      mac_data   <= '0;
      mac_eop    <= 1'b0;
      mac_no_crc <= 1'b0;
      mac_no_pad <= 1'b0;
    end
    else
    begin
      mac_eop <= 1'b0;
      if (mac_valid && mac_ready)
        mac_valid <= 1'b0;
      case (rst_q)
        etx_pkg::R_IDLE:
          if (can_start)
            rst_q <= etx_pkg::R_CMDA;
        etx_pkg::R_CMDA:
        begin
          rrem_q <= dhead[etx_pkg::CA_SIZE_LSB +: etx_pkg::CA_SIZE_W];
          // first byte lane from offset low bits
          lane_q <= dhead[etx_pkg::CA_OFF_LSB +: 2];
          rls_q  <= dhead[etx_pkg::CA_LS_BIT];
          if (dhead[etx_pkg::CA_FS_BIT])
            rst_q <= etx_pkg::R_CMDB;
          else if (dhead[etx_pkg::CA_SIZE_LSB +: etx_pkg::CA_SIZE_W] == 11'h000)
            rst_q <= dhead[etx_pkg::CA_LS_BIT] ? etx_pkg::R_EOP : etx_pkg::R_CMDA;
          else
            rst_q <= etx_pkg::R_DATA;
        end
        etx_pkg::R_CMDB:
        begin
          // CRC suppressed only while padding stays enabled
          mac_no_crc <= dhead[etx_pkg::CB_NOCRC_BIT] & ~dhead[etx_pkg::CB_NOPAD_BIT];
          mac_no_pad <= dhead[etx_pkg::CB_NOPAD_BIT];
          if (rrem_q == 11'h000)
            rst_q <= rls_q ? etx_pkg::R_EOP : etx_pkg::R_CMDA;
          else
            rst_q <= etx_pkg::R_DATA;
        end
        etx_pkg::R_DATA:
          if (slot_free)
          begin
            mac_valid <= 1'b1;
            mac_data  <= dhead[{lane_q, 3'h0} +: 8];
            lane_q    <= lane_q + 2'h1;
            rrem_q    <= rrem_q - 11'h001;
            if (rrem_q == 11'h001)
              rst_q <= rls_q ? etx_pkg::R_EOP : etx_pkg::R_CMDA;
          end
        etx_pkg::R_EOP:
          if (slot_free)
          begin
            mac_eop <= 1'b1;
            rst_q   <= etx_pkg::R_WAIT;
          end
        default:
          if (mac_done)
            rst_q <= etx_pkg::R_IDLE;
      endcase
    end
  end

  // Sticky error flag; a new error wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      transmit_error_flag <= 1'b0;
    // status overrun never raises the flag (suspension prevents it otherwise)
    else if (len_err || cmdb_err || (dpush && dfull))
      transmit_error_flag <= 1'b1;
    else if (wr_info_evt && pwdata[etx_pkg::INFO_ERR_BIT])
      transmit_error_flag <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mac_defer_check_en <= 1'b0;
    else
      mac_defer_check_en <= defer_en_q;
  end

  // APB answer: registered, ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= psel & ~penable;
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
      if (psel && !penable)
      begin
        if (paddr == etx_pkg::ADDR_DATA)
          prdata_q <= '0;
        else if (paddr == etx_pkg::ADDR_STATUS)
          prdata_q <= sempty ? etx_pkg::STATUS_RESET : smem[srp_q[SAW-1:0]];
        else if (paddr == etx_pkg::ADDR_CFG)
        begin
          prdata_q[etx_pkg::CFG_SAO_BIT]   <= sao_q;
          prdata_q[etx_pkg::CFG_DEFER_BIT] <= defer_en_q;
        end
        else if (paddr == etx_pkg::ADDR_INFO)
        begin
          // used count reads zero after overrun
          prdata_q[SAW:0]                  <= ovr_q ? '0 : scount;
          prdata_q[etx_pkg::INFO_ERR_BIT]  <= transmit_error_flag;
        end
        else
          pslverr_q <= 1'b1;
      end
    end
  end

  assign pready  = pready_q;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

endmodule

// ---- sim/etx_tx_path_asserts.sv ----
/*
  Port checker for the transmit command path, bound to etx_tx_path.
  Assumes the single pclk domain with presetn as asynchronous reset.
*/
`timescale 1ns/1ns
module etx_tx_path_asserts (
  // Bus and clock
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // MAC side
  input wire logic        mac_valid,
  input wire logic [7:0]  mac_data,
  input wire logic        mac_ready,
  input wire logic        mac_eop,
  input wire logic        mac_no_crc,
  input wire logic        mac_no_pad,
  input wire logic        mac_defer_check_en,
  input wire logic        transmit_error_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_RDY:
    assert property (psel && !penable |=> pready) else $error("pready late");
  AST_RDY_ONE:
    assert property (pready |=> !pready) else $error("pready too long");
  AST_PRD_ZERO:
    assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
  AST_SLVERR:
    assert property (pslverr |-> pready) else $error("pslverr alone");
  AST_NOCRC_PAD:
    assert property (mac_no_crc |-> !mac_no_pad) else $error("crc off with no pad");
  AST_HOLD:
    assert property (mac_valid && !mac_ready |=> mac_valid && $stable(mac_data))
      else $error("byte not held");
  AST_EOP_IDLE:
    assert property (mac_eop |-> !mac_valid ##1 !mac_eop) else $error("eop bad");
  AST_CMD_STABLE:
    assert property (mac_valid && $past(mac_valid) |-> $stable(mac_no_crc)
      && $stable(mac_no_pad)) else $error("crc pad moved");
  AST_ERR_STICKY:
    assert property (transmit_error_flag && !(psel && penable && pwrite
      && paddr == etx_pkg::ADDR_INFO) |=> transmit_error_flag)
      else $error("error flag lost");
  AST_DEFER:
    assert property (psel && penable && pready && pwrite && paddr == etx_pkg::ADDR_CFG
      |=> ##1 mac_defer_check_en == $past(pwdata[1], 2)) else $error("defer en");
endmodule

bind etx_tx_path etx_tx_path_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .mac_valid(mac_valid),
  .mac_data(mac_data), .mac_ready(mac_ready), .mac_eop(mac_eop),
  .mac_no_crc(mac_no_crc), .mac_no_pad(mac_no_pad),
  .mac_defer_check_en(mac_defer_check_en), .transmit_error_flag(transmit_error_flag));

// ---- sim/etx_mac_model.sv ----
/*
  MAC model: stalls at random, collects bytes, reports one result per packet.
  Assumes the bench sets res before the packet ends and reads got and ndone.
*/
`timescale 1ns/1ns
module etx_mac_model (
  // Stream in
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    mac_valid,
  input wire logic [7:0]              mac_data,
  input wire logic                    mac_eop,
  input wire etx_pkg::etx_mac_result_s res,
  // Answers
  output logic                        mac_ready,
  output logic                        mac_done,
  output etx_pkg::etx_mac_result_s    mac_result
);
  logic [7:0] got[$];
  int         ndone;
  int         wt;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mac_ready <= 1'b0;
      mac_done <= 1'b0;
      mac_result <= ~res;
      wt <= 0;
      ndone <= 0;
    end
    else
    begin
      mac_ready <= 1'($random);
      if (mac_valid && mac_ready)
        got.push_back(mac_data);
      mac_done <= 1'b0;
      // Result lines toggle outside the done pulse
      mac_result <= ~mac_result;
      if (mac_eop)
        wt <= 1 + ($random & 7);
      else if (wt > 1)
        wt <= wt - 1;
      else if (wt == 1)
      begin
        wt <= 0;
        mac_done <= 1'b1;
        mac_result <= res;
        ndone <= ndone + 1;
      end
    end
  end
endmodule

// ---- sim/test_eth_tx_buffer_command_path.sv ----
/*
  Self-checking bench: APB host tasks, random buffers, status checks.
  Assumes etx_tx_path with a small status FIFO and the MAC model.
*/
`timescale 1ns/1ns
module test_eth_tx_buffer_command_path;
  localparam int SD = 4;
  logic                     pclk = 0;
  logic                     presetn = 0;
  logic                     psel = 0;
  logic                     penable = 0;
  logic                     pwrite = 0;
  logic [11:0]              paddr = 12'h0;
  logic [31:0]              pwdata = 32'h0;
  logic                     pready;
  logic [31:0]              prdata;
  logic                     pslverr;
  logic                     mac_valid;
  logic [7:0]               mac_data;
  logic                     mac_ready;
  logic                     mac_eop;
  logic                     mac_no_crc;
  logic                     mac_no_pad;
  logic                     mac_defer_check_en;
  logic                     mac_done;
  etx_pkg::etx_mac_result_s mac_result;
  etx_pkg::etx_mac_result_s res = '0;
  logic                     transmit_error_flag;
  logic [31:0]              rd;
  logic                     er;
  logic                     dce = 0;
  logic [7:0]               exq[$];
  logic [31:0]              exs[$];
  int                       err_count = 0;
  int                       samples_checked = 0;
  int                       seed = 32'h547f;
  int                       nd = 0;

  etx_tx_path #(.SDEPTH(SD)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .mac_valid(mac_valid),
    .mac_data(mac_data), .mac_ready(mac_ready), .mac_eop(mac_eop),
    .mac_no_crc(mac_no_crc), .mac_no_pad(mac_no_pad),
    .mac_defer_check_en(mac_defer_check_en), .mac_done(mac_done),
    .mac_result(mac_result), .transmit_error_flag(transmit_error_flag));
  etx_mac_model mac (.pclk(pclk), .presetn(presetn), .mac_valid(mac_valid),
    .mac_data(mac_data), .mac_eop(mac_eop), .res(res), .mac_ready(mac_ready),
    .mac_done(mac_done), .mac_result(mac_result));

  always #50 pclk = ~pclk;

  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request stands until pready is seen high at a rising edge; only the watchdog ends a hang
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cfg(input logic sao, input logic d);
    dce = d;
    apb(1, etx_pkg::ADDR_CFG, {30'h0, d, sao});
  endtask

  task automatic bf(input int off, sz, al, fs, ls, input logic [31:0] cb);
    int m;
    int nw;
    logic [31:0] w;
    m = al == 0 ? 4 : al == 1 ? 16 : 32;
    nw = (off + sz + m - 1) / m * m / 4;
    apb(1, 0, {6'h0, 2'(al), 3'h0, 5'(off), 2'h3, 1'(fs), 1'(ls), 1'b1, 11'(sz)});
    apb(1, 0, cb);
    for (int i = 0; i < nw; i++)
    begin
      w = $random(seed);
      for (int j = 0; j < 4; j++)
        if (i * 4 + j >= off && i * 4 + j < off + sz)
          exq.push_back(w[8 * j +: 8]);
      apb(1, 0, w);
    end
  endtask

  function automatic logic [31:0] st(input logic [15:0] t, input logic [31:0] cb);
    logic x;
    x = res.excess_deferral & dce;
    return {t, |{res[9:6], x}, 3'h0, res[9:6], 1'b0, res.collision_count, x, 1'b0,
      res.deferred};
  endfunction

  task automatic fin(input logic [31:0] cb, input logic rs);
    int k;
    k = 0;
    while (mac.ndone <= nd && k < 3000)
    begin
      @(posedge pclk);
      k++;
    end
    nd++;
    chk("done", 1, k < 3000);
    exs.push_back(st(cb[31:16], cb));
    chk("count", exq.size(), mac.got.size());
    while (exq.size() > 0 && mac.got.size() > 0)
      chk("byte", exq.pop_front(), mac.got.pop_front());
    chk("no_crc", cb[13] & ~cb[12], mac_no_crc);
    chk("no_pad", cb[12], mac_no_pad);
    if (rs)
    begin
      apb(0, etx_pkg::ADDR_STATUS, 0);
      chk("status", exs.pop_front(), rd);
    end
  endtask

  // short packets, every segment at least four bytes
  task automatic pk(input int nb, dl, hold, rs);
    int s[3];
    int tl;
    logic [31:0] cb;
    tl = 0;
    for (int i = 0; i < nb; i++)
    begin
      s[i] = 4 + ($random(seed) & 63);
      tl += s[i];
    end
    res <= etx_pkg::etx_mac_result_s'(10'($random(seed)));
    cb = {16'($random(seed)), 2'h3, 2'($random(seed)), 1'b1, 11'(tl + dl)};
    for (int i = 0; i < nb; i++)
      bf(nb == 1 && nd == 0 ? 31 : $random(seed) & 31, s[i], $random(seed) & 3,
        i == 0, i == nb - 1, cb);
    if (hold)
    begin
      repeat (300) @(posedge pclk);
      chk("held", 0, mac.got.size());
      apb(0, etx_pkg::ADDR_STATUS, 0);
      chk("status", exs.pop_front(), rd);
    end
    fin(cb, rs);
  endtask

  task automatic drain(input int n);
    for (int i = 0; i < n; i++)
    begin
      apb(0, etx_pkg::ADDR_STATUS, 0);
      chk("status", exs.pop_front(), rd);
    end
  endtask

  initial
  begin
    #(100 * 90000);
    err_count++;
    $display("watchdog expired");
    end_of_test();
  end

  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, etx_pkg::ADDR_INFO, 0);
    chk("info", 0, rd);
    apb(0, etx_pkg::ADDR_STATUS, 0);
    chk("empty", 0, rd);
    apb(0, 12'h010, 0);
    chk("pslverr", 1, er);
    $display("registers done");
    for (int p = 0; p < 16; p++)
    begin
      cfg(0, p[2]);
      pk(p[0] ? 3 : 1, 0, 0, 1);
    end
    $display("random packets done");
    pk(1, 1, 0, 1);
    apb(0, etx_pkg::ADDR_INFO, 0);
    chk("len err", 1, rd[16]);
    apb(1, etx_pkg::ADDR_INFO, 32'h1_0000);
    apb(0, etx_pkg::ADDR_INFO, 0);
    chk("cleared", 0, rd[16]);
    bf(0, 0, 0, 1, 1, 32'h0);
    fin(32'h0, 1);
    chk("zero len", 0, transmit_error_flag);
    bf(0, 8, 0, 1, 0, 32'h0000_0010);
    bf(0, 8, 0, 0, 1, 32'h0001_0010);
    fin(32'h0, 0);
    exs.pop_back();
    apb(0, etx_pkg::ADDR_STATUS, 0);
    apb(0, etx_pkg::ADDR_INFO, 0);
    chk("cmdb err", 1, rd[16]);
    apb(1, etx_pkg::ADDR_INFO, 32'h1_0000);
    $display("error tests done");
    for (int p = 0; p < SD; p++)
      pk(1, 0, 0, 0);
    pk(1, 0, 1, 0);
    drain(SD);
    cfg(1, 1);
    for (int p = 0; p <= SD; p++)
      pk(1, 0, 0, 0);
    exs.pop_back();
    apb(0, etx_pkg::ADDR_INFO, 0);
    chk("overrun", 0, rd & 32'h1_001f);
    drain(SD);
    $display("status fifo tests done");
    end_of_test();
  end
endmodule
